// File: hw/lds_pkg.sv
// Constants for the LED driver routine setup and monitor register bank.
// Assumes the serial frame decoder hands over bank 0 accesses as address and data.
package lds_pkg;

    // Register addresses inside bank 0
    localparam logic [5:0] ADDR_LED_COUNT_SETUP   = 6'h09;
    localparam logic [5:0] ADDR_DELAY_SETUP       = 6'h0A;
    localparam logic [5:0] ADDR_CURRENT_MONITOR   = 6'h0C;
    localparam logic [5:0] ADDR_REG_MODE_READBACK = 6'h0F;

    // Field positions in the routine setup register
    localparam int COUNT_LSB      = 0;
    localparam int COUNT_MSB      = 3;
    localparam int FLOAT_DONE_BIT = 4;
    localparam int FLOAT_START_BIT = 5;
    localparam int HALVING_BIT    = 6;
    localparam int AMP_REDUCE_BIT = 7;

    // Field positions in the current monitor register
    localparam int LED_BAND_LSB   = 0;
    localparam int IN_BAND_LSB    = 2;
    localparam int MON_DONE_BIT   = 4;
    localparam int MON_START_BIT  = 5;

    // Field position in the regulation mode readback register
    localparam int MODE_LSB       = 2;

    // Values after reset
    localparam logic [3:0] RST_LED_COUNT  = 4'h8;
    localparam logic [7:0] RST_DELAY      = 8'h80;
    localparam logic [1:0] RST_LED_BAND   = 2'h0;
    localparam logic [1:0] RST_IN_BAND    = 2'h0;
    localparam logic [1:0] RST_REG_MODE   = 2'h1;

    // Regulation modes reported by the power stage
    typedef enum logic [1:0] {
        LDS_MODE_BUCK       = 2'h1,
        LDS_MODE_BOOST      = 2'h2,
        LDS_MODE_BUCK_BOOST = 2'h3
    } lds_mode_t;

endpackage : lds_pkg

// File: hw/lds_regs.sv
// Routine setup and monitor register bank of the LED driver controller.
// Assumes a frame decoder delivering one-cycle read and write strobes for
// bank 0, and routine engines that pulse a success flag when a run ends.
// Functional notes
// - Four-bit LED series count, resets to eight
// - Float routine done flag, set on success
// - Writing float start one clears done flag
// - Float start bit activates routine, resets zero
// - Halving bit halves peak limit during routine
// - Amp reduce bit applies only during routine
// - Eight-bit routine delay, resets to 0x80
// - LED current band in bits 1:0
// - Input current band in bits 3:2
// - Monitor done set on success, cleared by start
// - Monitor start bit launches monitoring routine
// - Regulation mode readback, buck after reset
// - Unmapped accesses ignored, reads give diagnosis
`timescale 1ns/10ps

module lds_regs #(
    parameter int ADDR_W = 6
) (
    // Clock and reset
    input  wire logic              i_sys_clk,
    input  wire logic              i_reset_n,
    // Register access from the frame decoder
    input  wire logic              i_wr_en,
    input  wire logic              i_rd_en,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [7:0]        i_wdata,
    output logic      [7:0]        o_rdata,
    output logic                   o_rd_ack,
    output logic                   o_rd_diag,
    // Float routine engine
    input  wire logic              i_float_routine_ok,
    output logic                   o_float_routine_active,
    output logic      [3:0]        o_led_series_count,
    output logic                   o_peak_limit_halving,
    output logic                   o_amp_current_reduce,
    output logic      [7:0]        o_float_routine_delay,
    // Current monitor engine
    input  wire logic              i_monitor_ok,
    input  wire logic [1:0]        i_led_current_band,
    input  wire logic [1:0]        i_input_current_band,
    output logic                   o_monitor_run,
    // Power stage mode
    input  wire logic [1:0]        i_regulation_mode
);

    // The address map is six bits wide; other widths would alias registers
    if (ADDR_W != 6) begin : g_bad_addr_w
        $error("lds_regs: ADDR_W must be 6");
    end

    logic       halving_q;
    logic       amp_reduce_q;
    logic       float_done_q;
    logic       monitor_done_q;
    logic [1:0] led_band_q;
    logic [1:0] in_band_q;
    logic [1:0] reg_mode_q;
    logic       wr_setup;
    logic       wr_delay;
    logic       wr_monitor;
    logic       float_start_wr;
    logic       monitor_start_wr;
    logic       mapped;
    logic [7:0] rd_mux;

    // Address decode of write strobes
    assign wr_setup         = i_wr_en && (i_addr == lds_pkg::ADDR_LED_COUNT_SETUP);
    assign wr_delay         = i_wr_en && (i_addr == lds_pkg::ADDR_DELAY_SETUP);
    assign wr_monitor       = i_wr_en && (i_addr == lds_pkg::ADDR_CURRENT_MONITOR);
    assign float_start_wr   = wr_setup && i_wdata[lds_pkg::FLOAT_START_BIT];
    assign monitor_start_wr = wr_monitor && i_wdata[lds_pkg::MON_START_BIT];

    // Setup fields of the routine setup register
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_led_series_count     <= lds_pkg::RST_LED_COUNT;
            o_float_routine_active <= 1'b0;
            halving_q              <= 1'b0;
            amp_reduce_q           <= 1'b0;
        end else if (wr_setup) begin
            o_led_series_count     <= i_wdata[lds_pkg::COUNT_MSB:lds_pkg::COUNT_LSB];
            o_float_routine_active <= i_wdata[lds_pkg::FLOAT_START_BIT];
            halving_q              <= i_wdata[lds_pkg::HALVING_BIT];
            amp_reduce_q           <= i_wdata[lds_pkg::AMP_REDUCE_BIT];
        end
    end

    // Routine delay, passed raw; the engine scales it to the switching rate
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_float_routine_delay <= lds_pkg::RST_DELAY;
        end else if (wr_delay) begin
            o_float_routine_delay <= i_wdata;
        end
    end

    // Halving and amp reduction reach the analog side only while the routine
    // runs, one cycle late, so a stale setting lingers one cycle after a stop at most
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_peak_limit_halving <= 1'b0;
            o_amp_current_reduce <= 1'b0;
        end else begin
            o_peak_limit_halving <= halving_q && o_float_routine_active;
            o_amp_current_reduce <= amp_reduce_q && o_float_routine_active;
        end
    end

    // Float done flag; a success in the same cycle as a restart wins
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            float_done_q <= 1'b0;
        end else if (i_float_routine_ok && o_float_routine_active) begin
            float_done_q <= 1'b1;
        end else if (float_start_wr) begin
            float_done_q <= 1'b0;
        end
    end

    // Monitor start bit
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_monitor_run <= 1'b0;
        end else if (wr_monitor) begin
            o_monitor_run <= i_wdata[lds_pkg::MON_START_BIT];
        end
    end

    // Monitor done flag; set wins over the clear of a restart
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            monitor_done_q <= 1'b0;
        end else if (i_monitor_ok && o_monitor_run) begin
            monitor_done_q <= 1'b1;
        end else if (monitor_start_wr) begin
            monitor_done_q <= 1'b0;
        end
    end

    // Current bands are captured when a monitoring run succeeds, so software
    // reads one coherent snapshot; writes never touch them
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            led_band_q <= lds_pkg::RST_LED_BAND;
            in_band_q  <= lds_pkg::RST_IN_BAND;
        end else if (i_monitor_ok && o_monitor_run) begin
            led_band_q <= i_led_current_band;
            in_band_q  <= i_input_current_band;
        end
    end

    // Regulation mode follows the power stage every cycle
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            reg_mode_q <= lds_pkg::RST_REG_MODE;
        end else begin
            reg_mode_q <= i_regulation_mode;
        end
    end

    // Read data multiplexer; unused bits read as zero
    always_comb begin
        rd_mux = 8'h00;
        mapped = 1'b1;
        unique case (i_addr)
            lds_pkg::ADDR_LED_COUNT_SETUP: begin
                rd_mux = {amp_reduce_q, halving_q, o_float_routine_active,
                          float_done_q, o_led_series_count};
            end
            lds_pkg::ADDR_DELAY_SETUP: begin
                rd_mux = o_float_routine_delay;
            end
            lds_pkg::ADDR_CURRENT_MONITOR: begin
                rd_mux = {2'h0, o_monitor_run, monitor_done_q, in_band_q, led_band_q};
            end
            lds_pkg::ADDR_REG_MODE_READBACK: begin
                rd_mux = {4'h0, reg_mode_q, 2'h0};
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    // Read answer one cycle after the strobe; an unmapped read leaves the
    // data untouched and asks the frame encoder for the diagnosis frame
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rdata   <= 8'h00;
            o_rd_ack  <= 1'b0;
            o_rd_diag <= 1'b0;
        end else begin
            o_rd_ack  <= i_rd_en && mapped;
            o_rd_diag <= i_rd_en && !mapped;
            if (i_rd_en && mapped) begin
                o_rdata <= rd_mux;
            end
        end
    end

    // Checks
    sequence float_restart_s;
        float_start_wr && !i_float_routine_ok;
    endsequence

    sequence float_success_s;
        i_float_routine_ok && o_float_routine_active;
    endsequence

    sequence monitor_success_s;
        i_monitor_ok && o_monitor_run;
    endsequence

    count_write_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        wr_setup |=> o_led_series_count == $past(i_wdata[3:0]))
        else $error("LED count not stored");

    float_done_set_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        float_success_s |=> float_done_q ##1 (float_done_q || $past(float_start_wr)))
        else $error("Float done not set");

    float_restart_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        float_restart_s |=> !float_done_q && o_float_routine_active)
        else $error("Float done not cleared on restart");

    float_start_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        float_start_wr |=> o_float_routine_active
            ##1 (o_peak_limit_halving == $past(halving_q)))
        else $error("Float routine not activated");

    halving_gate_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        o_peak_limit_halving |-> $past(o_float_routine_active) && $past(halving_q))
        else $error("Peak halving outside routine");

    amp_gate_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        $rose(o_amp_current_reduce) |-> $past(o_float_routine_active, 1) && $past(amp_reduce_q))
        else $error("Amp reduction outside routine");

    delay_write_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        wr_delay |=> o_float_routine_delay == $past(i_wdata))
        else $error("Delay not stored");

    delay_read_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (i_rd_en && i_addr == lds_pkg::ADDR_DELAY_SETUP)
            |=> o_rd_ack && o_rdata == $past(o_float_routine_delay))
        else $error("Delay readback wrong");

    led_band_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        monitor_success_s |=> led_band_q == $past(i_led_current_band))
        else $error("LED band not captured");

    in_band_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        monitor_success_s |=> in_band_q == $past(i_input_current_band))
        else $error("Input band not captured");

    mon_done_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (monitor_start_wr && !i_monitor_ok) |=> !monitor_done_q)
        else $error("Monitor done not cleared");

    mon_start_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        monitor_start_wr |=> o_monitor_run)
        else $error("Monitor not started");

    mode_read_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (i_rd_en && i_addr == lds_pkg::ADDR_REG_MODE_READBACK)
            |=> o_rd_ack && o_rdata == {4'h0, $past(reg_mode_q), 2'h0})
        else $error("Mode readback wrong");

    unmapped_read_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (i_rd_en && !mapped) |=> o_rd_diag && !o_rd_ack && $stable(o_rdata))
        else $error("Unmapped read not diverted");

    status_hold_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (wr_monitor && !i_monitor_ok) |=> $stable(led_band_q) && $stable(in_band_q))
        else $error("Status changed by write");

endmodule : lds_regs

// File: tb/tb.sv
// Self-checking bench for the routine setup and monitor register bank.
// Assumes the bank stands alone; the bench plays the frame decoder, both
// routine engines and the power stage, one idle cycle between accesses.
`timescale 1ns/10ps

module tb;
    // Design inputs, all given a value at time zero
    logic       i_sys_clk            = 1'b0;
    logic       i_reset_n            = 1'b0;
    logic       i_wr_en              = 1'b0;
    logic       i_rd_en              = 1'b0;
    logic [5:0] i_addr               = 6'h00;
    logic [7:0] i_wdata              = 8'h00;
    logic       i_float_routine_ok   = 1'b0;
    logic       i_monitor_ok         = 1'b0;
    logic [1:0] i_led_current_band   = 2'h0;
    logic [1:0] i_input_current_band = 2'h0;
    logic [1:0] i_regulation_mode    = 2'h1;
    // Design outputs
    logic [7:0] o_rdata;
    logic       o_rd_ack;
    logic       o_rd_diag;
    logic       o_float_routine_active;
    logic       o_peak_limit_halving;
    logic       o_amp_current_reduce;
    logic       o_monitor_run;
    logic [3:0] o_led_series_count;
    logic [7:0] o_float_routine_delay;
    // Bookkeeping: notes hold {diag expected, read data expected}
    int         fail_count  = 0;
    int         comparisons = 0;
    integer     seed        = 32'hFE2A7D9A;
    logic [8:0] notes[$];
    logic [7:0] r;
    logic [3:0] pb          = 4'h0;
    logic [5:0] um[4]       = '{6'h00, 6'h01, 6'h0B, 6'h3F};

    lds_regs #(.ADDR_W(6)) i_lds_regs (
        .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_wr_en(i_wr_en),
        .i_rd_en(i_rd_en), .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata),
        .o_rd_ack(o_rd_ack), .o_rd_diag(o_rd_diag),
        .i_float_routine_ok(i_float_routine_ok),
        .o_float_routine_active(o_float_routine_active),
        .o_led_series_count(o_led_series_count),
        .o_peak_limit_halving(o_peak_limit_halving),
        .o_amp_current_reduce(o_amp_current_reduce),
        .o_float_routine_delay(o_float_routine_delay), .i_monitor_ok(i_monitor_ok),
        .i_led_current_band(i_led_current_band),
        .i_input_current_band(i_input_current_band), .o_monitor_run(o_monitor_run),
        .i_regulation_mode(i_regulation_mode));

    // 125 MHz clock
    always #4 i_sys_clk = ~i_sys_clk;

    // Write access; the strobe drops one edge later so tasks never collide
    task automatic wr(input logic [5:0] ad, input logic [7:0] d);
        @(posedge i_sys_clk);
        i_wr_en <= 1'b1;
        i_addr  <= ad;
        i_wdata <= d;
        @(posedge i_sys_clk);
        i_wr_en <= 1'b0;
    endtask : wr

    // Read access; the expected answer is noted before the strobe
    task automatic rd(input logic [5:0] ad, input logic dg, input logic [7:0] d);
        notes.push_back({dg, d});
        @(posedge i_sys_clk);
        i_rd_en <= 1'b1;
        i_addr  <= ad;
        @(posedge i_sys_clk);
        i_rd_en <= 1'b0;
    endtask : rd

    // One-cycle success pulse from a routine engine
    task automatic ok_pulse(input logic mon);
        @(posedge i_sys_clk);
        i_monitor_ok       <= mon;
        i_float_routine_ok <= ~mon;
        @(posedge i_sys_clk);
        i_monitor_ok       <= 1'b0;
        i_float_routine_ok <= 1'b0;
    endtask : ok_pulse

    // Let a write and the one-cycle output lag land, then sample mid-cycle
    task automatic settle;
        repeat (2) @(posedge i_sys_clk);
        @(negedge i_sys_clk);
    endtask : settle

    // Compare a level output
    task automatic chk_out(input string nm, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk_out

    // Compare a read answer with the oldest note
    task automatic chk_rd(input logic [8:0] n);
        comparisons++;
        if (n[8] ? (o_rd_diag !== 1'b1 || o_rd_ack !== 1'b0)
                 : (o_rd_ack !== 1'b1 || o_rd_diag !== 1'b0 || o_rdata !== n[7:0])) begin
            fail_count++;
            $display("[FAIL] read expected %h seen %h", n, {o_rd_diag, o_rdata});
        end
    endtask : chk_rd

    // Watcher: every answer takes the oldest note; an answer with none fails
    always @(negedge i_sys_clk) begin
        if (o_rd_ack === 1'b1 || o_rd_diag === 1'b1) begin
            if (notes.size() == 0) begin
                // An answer nobody asked for always counts as a mismatch
                chk_out("unexpected answer", 8'h00, {6'h00, o_rd_diag, o_rd_ack});
            end else begin
                chk_rd(notes.pop_front());
            end
        end
    end

    task automatic final_report;
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : final_report

    // Watchdog: the whole sequence needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge i_sys_clk);
        fail_count++;
        final_report();
    end

    initial begin
        repeat (10) @(posedge i_sys_clk);
        i_reset_n <= 1'b1;
        rd(6'h09, 1'b0, 8'h08);
        rd(6'h0A, 1'b0, 8'h80);
        rd(6'h0C, 1'b0, 8'h00);
        rd(6'h0F, 1'b0, 8'h04);
        settle();
        chk_out("flags", 8'h00, {4'h0, o_float_routine_active, o_peak_limit_halving,
                o_amp_current_reduce, o_monitor_run});
        // unmapped writes vanish, unmapped reads give a diagnosis pulse
        foreach (um[i]) begin
            wr(um[i], 8'hFF);
            rd(um[i], 1'b1, 8'h00);
        end
        rd(6'h0A, 1'b0, 8'h80);
        // boundary and random settings; the done bit ignores writes
        for (int k = 0; k < 6; k++) begin
            r = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : 8'($random(seed));
            wr(6'h0A, r);
            wr(6'h09, r & 8'h1F);
            rd(6'h0A, 1'b0, r);
            rd(6'h09, 1'b0, r & 8'h0F);
            settle();
            chk_out("delay", r, o_float_routine_delay);
            chk_out("count", {4'h0, r[3:0]}, {4'h0, o_led_series_count});
        end
        // float routine run, rerun and stop
        wr(6'h09, 8'hE5);
        settle();
        chk_out("float", 8'h07, {5'h00, o_float_routine_active, o_peak_limit_halving,
                o_amp_current_reduce});
        rd(6'h09, 1'b0, 8'hE5);
        ok_pulse(1'b0);
        rd(6'h09, 1'b0, 8'hF5);
        wr(6'h09, 8'hF5);
        rd(6'h09, 1'b0, 8'hE5);
        ok_pulse(1'b0);
        wr(6'h09, 8'hC5);
        settle();
        chk_out("float", 8'h00, {5'h00, o_float_routine_active, o_peak_limit_halving,
                o_amp_current_reduce});
        rd(6'h09, 1'b0, 8'hD5);
        wr(6'h09, 8'h25);
        wr(6'h09, 8'h05);
        ok_pulse(1'b0);
        rd(6'h09, 1'b0, 8'h05);
        // restart and success in one cycle: the set wins
        wr(6'h09, 8'h25);
        @(posedge i_sys_clk);
        i_wr_en            <= 1'b1;
        i_wdata            <= 8'h25;
        i_float_routine_ok <= 1'b1;
        @(posedge i_sys_clk);
        i_wr_en            <= 1'b0;
        i_float_routine_ok <= 1'b0;
        rd(6'h09, 1'b0, 8'h35);
        // every band code, captured at monitor success
        for (int k = 0; k < 4; k++) begin
            wr(6'h0C, 8'hFF);
            rd(6'h0C, 1'b0, {4'h2, pb});
            i_led_current_band   <= 2'(k);
            i_input_current_band <= 2'(3 - k);
            ok_pulse(1'b1);
            i_led_current_band   <= 2'($random(seed));
            i_input_current_band <= 2'($random(seed));
            pb = {2'(3 - k), 2'(k)};
            rd(6'h0C, 1'b0, {4'h3, pb});
            chk_out("monitor run", 8'h01, {7'h00, o_monitor_run});
        end
        wr(6'h0C, 8'h20);
        wr(6'h0C, 8'h00);
        ok_pulse(1'b1);
        rd(6'h0C, 1'b0, {4'h0, pb});
        // every mode; the readback ignores writes
        for (int k = 1; k < 4; k++) begin
            i_regulation_mode <= 2'(k);
            wr(6'h0F, 8'hF3);
            rd(6'h0F, 1'b0, {4'h0, 2'(k), 2'b00});
        end
        settle();
        chk_out("pending reads", 8'h00, 8'(notes.size()));
        final_report();
    end
endmodule : tb
